// ===== inc/remap_pkg.sv
// Shared constants and types for the remote-target alias remapping logic.
// Assumes one clock domain and an 8-bit register port owned by the block.
package remap_pkg;
  localparam int DATA_W = 8;
  localparam int REG_ADDR_W = 8;
  localparam int I2C_ADDR_W = 7;
  localparam int NUM_PHYS = 3;
  localparam int NUM_ALIAS = 2;
  localparam int NUM_REGS = NUM_PHYS + NUM_ALIAS;
  localparam int IDX_PHYS_FIRST = 0;
  localparam int IDX_ALIAS_FIRST = NUM_PHYS;
  localparam int CNT_W = 8;
  // Register byte addresses.
  localparam logic [7:0] OFS_PHYS_5 = 8'h0D;
  localparam logic [7:0] OFS_PHYS_6 = 8'h0E;
  localparam logic [7:0] OFS_PHYS_7 = 8'h0F;
  localparam logic [7:0] OFS_ALIAS_0 = 8'h10;
  localparam logic [7:0] OFS_ALIAS_1 = 8'h11;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_HIT_CNT = 8'h19;
  localparam logic [7:0] OFS_MISS_CNT = 8'h1A;
  localparam logic [NUM_REGS-1:0][7:0] REG_OFS =
    {OFS_ALIAS_1, OFS_ALIAS_0, OFS_PHYS_7, OFS_PHYS_6, OFS_PHYS_5};
  // Field layout and reset values.
  localparam int ADDR_FIELD_MSB = 7;
  localparam int ADDR_FIELD_LSB = 1;
  localparam int RW_BIT = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] PHYS_WMASK = 8'hFF;
  localparam logic [7:0] ALIAS_WMASK = 8'hFE;
  localparam logic [NUM_REGS-1:0][7:0] REG_WMASK =
    {ALIAS_WMASK, ALIAS_WMASK, PHYS_WMASK, PHYS_WMASK, PHYS_WMASK};
  localparam logic [6:0] ALIAS_DISABLED = 7'h00;
  // Status register bit positions.
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_LAST_HIT_BIT = 1;
  localparam int STAT_SLOT_BIT = 2;
  // One I2C byte as seen by the remapper.
  typedef struct packed {
    logic is_addr;
    logic [7:0] data;
  } i2c_byte_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PASS = 2'b01,
    ST_DROP = 2'b10
  } xfer_state_t;
endpackage

// ===== logic/remap_regs.sv
// Storage for the physical-address and alias slot registers.
// Assumes write enables are already decoded and one-hot.
`timescale 1ns/1ps
module remap_regs #(
  parameter int N = remap_pkg::NUM_REGS
) (
  input wire logic clock, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic [N-1:0] wr_en, // One write enable per register.
  input wire logic [7:0] wdata, // Write data.
  output logic [N-1:0][7:0] value // Stored register values.
);
  import remap_pkg::*;

  logic [N-1:0][7:0] val_q;
  logic [N-1:0][7:0] val_d;

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_reg
      // Masked bits keep zero, so read-only reserved bits never hold a one.
      always_comb
      begin
        val_d[i] = val_q[i];
        if (wr_en[i])
        begin
          val_d[i] = wdata & REG_WMASK[i];
        end
      end

      // All slots clear to zero, which leaves every alias disabled after reset.
      always_ff @(posedge clock or negedge nrst)
      begin
        if (!nrst)
        begin
          val_q[i] <= REG_RESET;
        end
        else
        begin
          val_q[i] <= val_d[i];
        end
      end
    end
  endgenerate

  assign value = val_q;
endmodule

// ===== logic/alias_matcher.sv
// Compares an incoming I2C target address against every alias slot.
// Assumes alias values are stable register outputs on the same clock.
`timescale 1ns/1ps
module alias_matcher #(
  parameter int N = remap_pkg::NUM_ALIAS
) (
  input wire logic [6:0] probe, // Target address from the address byte.
  input wire logic [N-1:0][6:0] alias_addr, // Programmed alias per slot.
  output logic hit, // Some enabled slot matches.
  output logic [$clog2(N > 1 ? N : 2)-1:0] slot // Lowest matching slot.
);
  import remap_pkg::*;

  localparam int SLOT_W = $clog2(N > 1 ? N : 2);
  logic [N-1:0] slot_hit;

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_cmp
      // A zero alias would otherwise claim the general call address.
      assign slot_hit[i] = (alias_addr[i] != ALIAS_DISABLED)
                           && (alias_addr[i] == probe);
    end
  endgenerate

  // Lowest slot wins when software programs the same alias twice.
  always_comb
  begin
    hit = 1'b0;
    slot = '0;
    for (int k = N - 1; k >= 0; k--)
    begin
      if (slot_hit[k])
      begin
        hit = 1'b1;
        slot = SLOT_W'(k);
      end
    end
  end
endmodule

// ===== logic/i2c_remote_alias_remap.sv
// Alias detection and address remapping for I2C pass-through to targets
// behind a remote serializer, plus its registers on a plain register port.
// Assumes an I2C engine on the same clock delivers bytes, marks the address
// byte of each start or repeated start, and signals the stop.
// How it works
// - Physical slots keep a 7-bit address in bits 7..1; bit 0 writable.
// - A transaction hitting an alias is forwarded with the physical address.
// - Alias slots hold a 7-bit address compared against incoming targets.
// - An alias equal to zero never matches and forwards nothing.
// - Alias slot N always uses physical slot N as its target.
// - Alias bit 0 reads zero and ignores writes; bits 7..1 read/write.
`timescale 1ns/1ps
module i2c_remote_alias_remap #(
  parameter int CNT_WIDTH = remap_pkg::CNT_W
) (
  input wire logic clock, // 10 MHz system clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic [7:0] reg_addr, // Register byte address.
  input wire logic [7:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe, one cycle.
  input wire logic reg_rd, // Read strobe, one cycle.
  output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd.
  input wire logic in_valid, // A byte from the local I2C engine.
  input wire remap_pkg::i2c_byte_t in_byte, // Byte and address-byte flag.
  input wire logic in_stop, // Stop condition seen on the local bus.
  input wire logic [remap_pkg::NUM_ALIAS-1:0][6:0] phys_addr_low, // Slots 0..1.
  output logic [remap_pkg::NUM_PHYS-1:0][6:0] phys_addr_high, // Slots 5..7.
  output logic out_valid, // A byte for the control channel.
  output remap_pkg::i2c_byte_t out_byte, // Forwarded byte.
  output logic out_slot, // Alias slot of the forwarded transaction.
  output logic out_miss // Address byte that matched no alias.
);
  import remap_pkg::*;

  logic [NUM_REGS-1:0] reg_sel;
  logic [NUM_REGS-1:0] reg_wr_en;
  logic [NUM_REGS-1:0][7:0] reg_val;
  logic [NUM_ALIAS-1:0][6:0] alias_val;
  logic match_hit;
  logic match_slot;
  logic [6:0] remap_addr;

  xfer_state_t state_q;
  xfer_state_t state_d;
  logic out_valid_q;
  logic out_valid_d;
  i2c_byte_t out_byte_q;
  i2c_byte_t out_byte_d;
  logic out_slot_q;
  logic out_slot_d;
  logic out_miss_q;
  logic out_miss_d;
  logic last_hit_q;
  logic last_hit_d;
  logic cur_slot_q;
  logic cur_slot_d;

  logic [CNT_WIDTH-1:0] hit_cnt_q;
  logic [CNT_WIDTH-1:0] hit_cnt_d;
  logic [CNT_WIDTH-1:0] miss_cnt_q;
  logic [CNT_WIDTH-1:0] miss_cnt_d;
  logic hit_evt;
  logic miss_evt;

  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] status_val;

  // Address decode for the slot registers; unmapped writes go nowhere.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++)
    begin : g_dec
      assign reg_sel[gi] = (reg_addr == REG_OFS[gi]);
      assign reg_wr_en[gi] = reg_sel[gi] && reg_wr;
    end
  endgenerate

  remap_regs #(
    .N(NUM_REGS)
  ) u_regs (
    .clock(clock),
    .nrst(nrst),
    .wr_en(reg_wr_en),
    .wdata(reg_wdata),
    .value(reg_val)
  );

  // Physical slots 5..7 serve alias slots of the same number elsewhere.
  generate
    for (gi = 0; gi < NUM_PHYS; gi++)
    begin : g_phys
      assign phys_addr_high[gi] =
        reg_val[IDX_PHYS_FIRST + gi][ADDR_FIELD_MSB:ADDR_FIELD_LSB];
    end
    for (gi = 0; gi < NUM_ALIAS; gi++)
    begin : g_alias
      assign alias_val[gi] =
        reg_val[IDX_ALIAS_FIRST + gi][ADDR_FIELD_MSB:ADDR_FIELD_LSB];
    end
  endgenerate

  alias_matcher #(
    .N(NUM_ALIAS)
  ) u_match (
    .probe(in_byte.data[ADDR_FIELD_MSB:ADDR_FIELD_LSB]),
    .alias_addr(alias_val),
    .hit(match_hit),
    .slot(match_slot)
  );

  // The physical slot with the same number as the matching alias is used.
  assign remap_addr = phys_addr_low[match_slot];

  // Transaction tracking: every address byte decides afresh, so a repeated
  // start to another alias is remapped on its own.
  always_comb
  begin
    state_d = state_q;
    out_valid_d = 1'b0;
    out_byte_d = out_byte_q;
    out_slot_d = out_slot_q;
    out_miss_d = 1'b0;
    last_hit_d = last_hit_q;
    cur_slot_d = cur_slot_q;
    hit_evt = 1'b0;
    miss_evt = 1'b0;
    if (in_valid && in_byte.is_addr)
    begin
      if (match_hit)
      begin
        state_d = ST_PASS;
        out_valid_d = 1'b1;
        out_byte_d.is_addr = 1'b1;
        out_byte_d.data = {remap_addr, in_byte.data[RW_BIT]};
        out_slot_d = match_slot;
        cur_slot_d = match_slot;
        last_hit_d = 1'b1;
        hit_evt = 1'b1;
      end
      else
      begin
        state_d = ST_DROP;
        out_miss_d = 1'b1;
        last_hit_d = 1'b0;
        miss_evt = 1'b1;
      end
    end
    else if (in_valid)
    begin
      unique case (state_q)
        ST_PASS:
        begin
          out_valid_d = 1'b1;
          out_byte_d = in_byte;
          out_slot_d = cur_slot_q;
        end
        ST_IDLE, ST_DROP:
        begin
          out_valid_d = 1'b0;
        end
        default:
        begin
          state_d = ST_IDLE;
        end
      endcase
    end
    // A byte in the stop cycle is still handled before the transaction ends.
    if (in_stop)
    begin
      state_d = ST_IDLE;
    end
  end

  // Forwarded bytes leave one cycle after they arrive, from flip-flops.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= ST_IDLE;
      out_valid_q <= 1'b0;
      out_byte_q <= '0;
      out_slot_q <= 1'b0;
      out_miss_q <= 1'b0;
      last_hit_q <= 1'b0;
      cur_slot_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      out_valid_q <= out_valid_d;
      out_byte_q <= out_byte_d;
      out_slot_q <= out_slot_d;
      out_miss_q <= out_miss_d;
      last_hit_q <= last_hit_d;
      cur_slot_q <= cur_slot_d;
    end
  end

  assign out_valid = out_valid_q;
  assign out_byte = out_byte_q;
  assign out_slot = out_slot_q;
  assign out_miss = out_miss_q;

  // Saturating event counters; a write clears one, but an event in the
  // same cycle still counts so that no hit is lost.
  always_comb
  begin
    hit_cnt_d = hit_cnt_q;
    miss_cnt_d = miss_cnt_q;
    if (reg_wr && (reg_addr == OFS_HIT_CNT))
    begin
      hit_cnt_d = '0;
    end
    if (reg_wr && (reg_addr == OFS_MISS_CNT))
    begin
      miss_cnt_d = '0;
    end
    if (hit_evt && (hit_cnt_d != '1))
    begin
      hit_cnt_d = hit_cnt_d + 1'b1;
    end
    if (miss_evt && (miss_cnt_d != '1))
    begin
      miss_cnt_d = miss_cnt_d + 1'b1;
    end
  end

  // Counters register their next values only.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      hit_cnt_q <= '0;
      miss_cnt_q <= '0;
    end
    else
    begin
      hit_cnt_q <= hit_cnt_d;
      miss_cnt_q <= miss_cnt_d;
    end
  end

  // Status shows the live transaction state and the last decision.
  always_comb
  begin
    status_val = '0;
    status_val[STAT_ACTIVE_BIT] = (state_q == ST_PASS);
    status_val[STAT_LAST_HIT_BIT] = last_hit_q;
    status_val[STAT_SLOT_BIT] = cur_slot_q;
  end

  // Read mux; unmapped addresses and idle cycles return zero.
  always_comb
  begin
    rdata_d = '0;
    if (reg_rd)
    begin
      for (int k = 0; k < NUM_REGS; k++)
      begin
        if (reg_sel[k])
        begin
          rdata_d = reg_val[k];
        end
      end
      if (reg_addr == OFS_STATUS)
      begin
        rdata_d = status_val;
      end
      if (reg_addr == OFS_HIT_CNT)
      begin
        rdata_d = 8'(hit_cnt_q);
      end
      if (reg_addr == OFS_MISS_CNT)
      begin
        rdata_d = 8'(miss_cnt_q);
      end
    end
  end

  // Read data are held only for the one cycle after the strobe.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
endmodule

// ===== tb/remap_checker.sv
// Concurrent checks on the ports of the alias remapper.
// Assumes one clock domain; attached to the top module by bind.
`timescale 1ns/1ps
module remap_checker
  import remap_pkg::*;
#(
  parameter int CNT_WIDTH = 8
) (
  input wire logic clock, // Clock.
  input wire logic nrst, // Reset, active low.
  input wire logic [7:0] reg_addr, // Register address.
  input wire logic [7:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  input wire logic [7:0] reg_rdata, // Read data.
  input wire logic in_valid, // Incoming byte strobe.
  input wire remap_pkg::i2c_byte_t in_byte, // Incoming byte.
  input wire logic [NUM_ALIAS-1:0][6:0] phys_addr_low, // Slots 0 and 1.
  input wire logic [NUM_PHYS-1:0][6:0] phys_addr_high, // Slots 5 to 7.
  input wire logic out_valid, // Forwarded byte strobe.
  input wire remap_pkg::i2c_byte_t out_byte, // Forwarded byte.
  input wire logic out_slot, // Slot of the transaction.
  input wire logic out_miss // Address byte without a match.
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // An address byte is answered by a forward that keeps the direction bit, or by a miss.
  sequence addr_in;
    in_valid && in_byte.is_addr;
  endsequence
  sequence fwd_or_miss;
    (out_valid && out_byte.data[0] == $past(in_byte.data[0])) || out_miss;
  endsequence
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_ALIAS_BIT0: assert property (reg_rd && reg_addr[7:1] == 7'h08 |=> !reg_rdata[0])
    else $error("alias bit 0 read as one");
  AST_PHYS_WR: assert property (reg_wr && reg_addr == OFS_PHYS_5
    |=> phys_addr_high[0] == $past(reg_wdata[7:1])) else $error("slot 5 field not written");
  AST_FWD_CAUSE: assert property (out_valid |-> $past(in_valid))
    else $error("forward without an incoming byte");
  AST_MISS_CAUSE: assert property (out_miss |-> $past(in_valid && in_byte.is_addr))
    else $error("miss without an address byte");
  AST_ADDR_ANSWER: assert property (addr_in |=> fwd_or_miss)
    else $error("address byte answer wrong");
  AST_ZERO_ALIAS: assert property (addr_in ##0 in_byte.data[7:1] == 7'h00
    |=> out_miss && !out_valid) else $error("zero address was forwarded");
  AST_PAIR: assert property (out_valid && out_byte.is_addr
    |-> out_byte.data[7:1] == phys_addr_low[out_slot]) else $error("wrong physical slot");
  AST_DATA_PASS: assert property (in_valid && !in_byte.is_addr
    |=> !out_valid || out_byte == $past(in_byte)) else $error("data byte altered");
endmodule
bind i2c_remote_alias_remap remap_checker #(.CNT_WIDTH(CNT_WIDTH)) checker_i (
  .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
  .in_byte(in_byte), .phys_addr_low(phys_addr_low), .phys_addr_high(phys_addr_high),
  .out_valid(out_valid), .out_byte(out_byte), .out_slot(out_slot), .out_miss(out_miss));

// ===== tb/far_side_model.sv
// Model of the far side: the neighbouring slot store and the channel sink.
// Assumes forwarded bytes arrive as one-cycle pulses on the block clock.
`timescale 1ns/1ps
module far_side_model #(
  parameter logic [6:0] PHYS0 = 7'h21,
  parameter logic [6:0] PHYS1 = 7'h3C
) (
  input wire logic clock, // Clock.
  input wire logic nrst, // Reset, active low.
  input wire logic out_valid, // Forwarded byte strobe.
  output logic [remap_pkg::NUM_ALIAS-1:0][6:0] phys_addr_low, // Slots 0 and 1.
  output logic [7:0] rx_count // Bytes taken from the channel.
);
  // Slot index equals alias index, so slot 0 sits in the low lane.
  assign phys_addr_low = {PHYS1, PHYS0};
  // The sink takes every pulse; it never stalls, as the channel has no backpressure.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rx_count <= 8'h00;
    else if (out_valid)
      rx_count <= rx_count + 8'h01;
  end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the alias remapper and its registers.
// Assumes the checker is bound in and the far-side model supplies slots 0 and 1.
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    n_compared++; \
    if ((got) !== (ex)) \
    begin \
      failures++; \
      $display("mismatch %s expected %h seen %h", nm, ex, got); \
    end \
  end
module testbench;
  import remap_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic in_valid = 1'b0;
  i2c_byte_t in_byte = '0;
  logic in_stop = 1'b0;
  logic [NUM_ALIAS-1:0][6:0] phys_addr_low;
  logic [NUM_PHYS-1:0][6:0] phys_addr_high;
  logic out_valid;
  i2c_byte_t out_byte;
  logic out_slot;
  logic out_miss;
  logic [7:0] rx_count;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  i2c_remote_alias_remap DUT (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .in_valid(in_valid), .in_byte(in_byte), .in_stop(in_stop),
    .phys_addr_low(phys_addr_low), .phys_addr_high(phys_addr_high),
    .out_valid(out_valid), .out_byte(out_byte), .out_slot(out_slot), .out_miss(out_miss));
  far_side_model far (.clock(clock), .nrst(nrst), .out_valid(out_valid),
    .phys_addr_low(phys_addr_low), .rx_count(rx_count));
  // A 100 ns clock.
  always #50 clock = ~clock;
  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // The run is under a hundred cycles, so a hang is cut far above that.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      final_report();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Read data is registered at the taking edge, so it is looked at just after it.
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 `CHK("reg_rdata", ex, reg_rdata)
  endtask
  task automatic send(input logic a, input logic [7:0] d, input logic ev, input logic mv,
    input logic [8:0] eb);
    @(posedge clock);
    in_valid <= 1'b1;
    in_byte <= {a, d};
    @(posedge clock);
    in_valid <= 1'b0;
    #1 `CHK("out_valid", ev, out_valid)
    `CHK("out_miss", mv, out_miss)
    if (ev)
      `CHK("out_byte", eb, out_byte)
  endtask
  task automatic t_reset();
    rd(OFS_PHYS_5, 8'h00);
    rd(OFS_PHYS_6, 8'h00);
    rd(OFS_PHYS_7, 8'h00);
    rd(OFS_ALIAS_0, 8'h00);
    rd(OFS_ALIAS_1, 8'h00);
    rd(8'h05, 8'h00);
  endtask
  task automatic t_regs();
    wr(OFS_PHYS_5, 8'hFF);
    rd(OFS_PHYS_5, 8'hFF);
    wr(OFS_ALIAS_0, 8'hFF);
    rd(OFS_ALIAS_0, 8'hFE);
    wr(OFS_ALIAS_1, 8'h01);
    rd(OFS_ALIAS_1, 8'h00);
    wr(OFS_PHYS_6, 8'h9B);
    // The slot takes the write at the edge the task returns on, so look just after it.
    #1 `CHK("phys_addr_high", 7'h4D, phys_addr_high[1])
    wr(OFS_PHYS_7, 8'h02);
    rd(OFS_PHYS_7, 8'h02);
    `CHK("phys_addr_high", 7'h7F, phys_addr_high[0])
    `CHK("phys_addr_high", 7'h01, phys_addr_high[2])
  endtask
  task automatic t_fwd();
    wr(OFS_ALIAS_0, 8'hA0);
    wr(OFS_ALIAS_1, 8'h62);
    send(1'b1, 8'hA1, 1'b1, 1'b0, 9'h143);
    `CHK("out_slot", 1'b0, out_slot)
    send(1'b0, 8'h5A, 1'b1, 1'b0, 9'h05A);
    send(1'b1, 8'h62, 1'b1, 1'b0, 9'h178);
    `CHK("out_slot", 1'b1, out_slot)
    rd(OFS_STATUS, 8'h07);
    @(posedge clock);
    in_stop <= 1'b1;
    @(posedge clock);
    in_stop <= 1'b0;
    // After the stop no transaction is open, so a stray data byte goes nowhere.
    send(1'b0, 8'h44, 1'b0, 1'b0, 9'h000);
  endtask
  task automatic t_disabled();
    wr(OFS_ALIAS_0, 8'h00);
    send(1'b1, 8'h00, 1'b0, 1'b1, 9'h000);
    send(1'b0, 8'h33, 1'b0, 1'b0, 9'h000);
    send(1'b1, 8'hA1, 1'b0, 1'b1, 9'h000);
    `CHK("rx_count", 8'h03, rx_count)
  endtask
  // Own counters and status: a status write is ignored, and a hit in the
  // clearing cycle still counts, so the counter reads one afterwards.
  task automatic t_counts();
    rd(OFS_HIT_CNT, 8'h02);
    rd(OFS_MISS_CNT, 8'h02);
    wr(OFS_STATUS, 8'hFF);
    rd(OFS_STATUS, 8'h04);
    fork
      wr(OFS_HIT_CNT, 8'h00);
      send(1'b1, 8'h62, 1'b1, 1'b0, 9'h178);
    join
    rd(OFS_HIT_CNT, 8'h01);
    rd(OFS_STATUS, 8'h07);
    wr(OFS_MISS_CNT, 8'h00);
    rd(OFS_MISS_CNT, 8'h00);
  endtask
  // Reset for six cycles, then the scenarios in turn.
  initial
  begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_regs();
    t_fwd();
    t_disabled();
    t_counts();
    final_report();
  end
endmodule
